// ### shared/irq_ctrl_pkg.sv
package irq_ctrl_pkg;

    localparam int NUM_SRC = 24;
    localparam int NUM_SLOT = 10;
    localparam int NUM_EXT_TOP = 2;
    localparam int VEC_W = 17;
    localparam int LVL_W = 2;
    localparam int NEST_DEPTH = 3;

    // first vector address and spacing between slots
    localparam logic [VEC_W-1:0] VEC_BASE = 17'h00003;
    localparam logic [VEC_W-1:0] VEC_STEP = 17'h00008;

    // service levels, gray-coded along low, high, top; compare them through a rank
    typedef enum logic [1:0] {
        LVL_NONE = 2'h0,
        LVL_LOW = 2'h1,
        LVL_HIGH = 2'h3,
        LVL_TOP = 2'h2
    } lvl_t;

    // bit positions of the sources in the gathered request word
    localparam int SRC_EXT0 = 0;
    localparam int SRC_EXT1 = 1;
    localparam int SRC_EXT2 = 2;
    localparam int SRC_EXT4 = 4;
    localparam int SRC_EXT5 = 7;
    localparam int SRC_PORT0 = 20;

    // sources grouped onto each vector slot
    localparam logic [NUM_SRC-1:0] SLOT_MASK [NUM_SLOT] = '{
        24'h000001, 24'h000002, 24'h00003C, 24'h0003C0, 24'h000400,
        24'h001800, 24'h006000, 24'h018000, 24'h0E0000, 24'hF00000
    };

    localparam lvl_t LVL_RESET = LVL_NONE;
    localparam logic [NUM_SRC-1:0] FLAGS_RESET = 24'h000000;
    localparam logic [VEC_W-1:0] VEC_RESET = 17'h00000;

endpackage

// ### logic/level_stack.sv
module level_stack
    import irq_ctrl_pkg::*;
#(
    parameter int DEPTH = NEST_DEPTH
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic push_i,
    input wire logic pop_i,
    input wire lvl_t data_i,
    output lvl_t top_o
);
    lvl_t mem_q [DEPTH];

    // shift stack: entry 0 is the top, pops refill the bottom with no level
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= LVL_RESET;
            end
        end else if (push_i) begin
            mem_q[0] <= data_i;
            for (int i = 1; i < DEPTH; i++) begin
                mem_q[i] <= mem_q[i-1];
            end
        end else if (pop_i) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                mem_q[i] <= mem_q[i+1];
            end
            mem_q[DEPTH-1] <= LVL_NONE;
        end
    end

    assign top_o = mem_q[0];

endmodule // level_stack

// ### logic/vectored_irq_ctrl.sv
// Operation
// - 24 sources gathered into 10 vector slots
// - three nested levels; equal or lower refused
// - highest over high over low; slots 1-2 only
// - greatest pending level granted first
// - same level: smallest vector address wins
// - vectors 00003H step eight to 0004BH
// - slot 3 shares four sources at 00013H
// - slot 4 shares four sources at 0001BH
// - slots 7, 8 serial; slot 9 converter and timers
// - latched flag list shows which sources fired
// - ext 0/1 wake only when level-detected
module vectored_irq_ctrl
    import irq_ctrl_pkg::*;
(
    input wire logic clk_i,
    input wire logic srst_i,
    // peripheral request flags, held high until the handler clears them
    input wire logic ext_request_0_i,
    input wire logic ext_request_1_i,
    input wire logic ext_request_2_i,
    input wire logic timer0_low_event_i,
    input wire logic ext_request_4_i,
    input wire logic ir_receiver_event_i,
    input wire logic ext_request_3_i,
    input wire logic ext_request_5_i,
    input wire logic base_timer_event_a_i,
    input wire logic base_timer_event_b_i,
    input wire logic timer0_high_event_i,
    input wire logic timer1_low_event_i,
    input wire logic timer1_high_event_i,
    input wire logic sync_serial_0_i,
    input wire logic uart_receive_i,
    input wire logic async_sync_serial_1_i,
    input wire logic uart_transmit_i,
    input wire logic converter_done_i,
    input wire logic eight_bit_timer_c_i,
    input wire logic eight_bit_timer_d_i,
    input wire logic port0_event_i,
    input wire logic eight_bit_timer_a_i,
    input wire logic eight_bit_timer_b_i,
    input wire logic twelve_bit_modulators_i,
    // configuration
    input wire logic [NUM_SLOT-1:0] slot_enable_i,
    input wire logic [NUM_SLOT-1:0] slot_high_i,
    input wire logic [NUM_EXT_TOP-1:0] ext_top_i,
    input wire logic [NUM_EXT_TOP-1:0] ext_level_detect_i,
    // core side
    input wire logic irq_ack_i,
    input wire logic irq_return_i,
    output logic irq_req_o,
    output logic [VEC_W-1:0] vector_o,
    output logic [NUM_SRC-1:0] source_flag_list_o,
    output lvl_t service_level_o,
    output logic wake_o
);

    logic [NUM_SRC-1:0] src_req;
    lvl_t cur_q;
    lvl_t cur_d;
    lvl_t stack_top;
    logic req_q;
    logic req_d;
    logic [VEC_W-1:0] vec_q;
    logic [VEC_W-1:0] vec_d;
    lvl_t win_lvl_q;
    lvl_t win_lvl_d;
    logic [3:0] win_slot_q;
    logic [3:0] win_slot_d;
    logic [NUM_SRC-1:0] flags_q;
    logic wake_q;
    logic wake_d;
    logic accept;
    logic leave;

    // gather every source into one word, in slot order
    assign src_req = {
        twelve_bit_modulators_i, eight_bit_timer_b_i, eight_bit_timer_a_i,
        port0_event_i,
        eight_bit_timer_d_i, eight_bit_timer_c_i, converter_done_i,
        uart_transmit_i, async_sync_serial_1_i,
        uart_receive_i, sync_serial_0_i,
        timer1_high_event_i, timer1_low_event_i, timer0_high_event_i,
        base_timer_event_b_i, base_timer_event_a_i, ext_request_5_i,
        ext_request_3_i,
        ir_receiver_event_i, ext_request_4_i, timer0_low_event_i,
        ext_request_2_i,
        ext_request_1_i, ext_request_0_i
    };

    // larger rank means more urgent; gray-coded levels need a translation
    function automatic logic [1:0] rank(input lvl_t l);
        case (l)
            LVL_LOW: rank = 2'h1;
            LVL_HIGH: rank = 2'h2;
            LVL_TOP: rank = 2'h3;
            default: rank = 2'h0;
        endcase
    endfunction

    // configured level of a slot; only the first two may be set to top
    function automatic lvl_t slot_level(input int s);
        lvl_t l;
        l = slot_high_i[s] ? LVL_HIGH : LVL_LOW;
        if (s < NUM_EXT_TOP && ext_top_i[s]) begin
            l = LVL_TOP;
        end
        return l;
    endfunction

    function automatic logic [VEC_W-1:0] slot_vector(input logic [3:0] s);
        logic [VEC_W-1:0] v;
        v = VEC_BASE + VEC_STEP * VEC_W'(s);
        return v;
    endfunction

    assign accept = req_q && irq_ack_i;
    // an accept in the same cycle as a return takes precedence
    assign leave = irq_return_i && !accept;

    // service level after this edge
    always_comb begin
        cur_d = cur_q;
        if (accept) begin
            cur_d = win_lvl_q;
        end else if (leave) begin
            cur_d = stack_top;
        end
    end

    level_stack #(
        .DEPTH(NEST_DEPTH)
    ) u_stack (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .push_i(accept),
        .pop_i(leave),
        .data_i(cur_q),
        .top_o(stack_top)
    );

    // pick the slot to offer, judged against the level that will stand
    always_comb begin
        lvl_t l;
        l = LVL_NONE;
        win_lvl_d = LVL_NONE;
        win_slot_d = 4'h0;
        for (int s = 0; s < NUM_SLOT; s++) begin
            l = slot_level(s);
            // strictly greater keeps the smaller index on ties
            if (slot_enable_i[s] && |(src_req & SLOT_MASK[s])
                    && rank(l) > rank(win_lvl_d)) begin
                win_lvl_d = l;
                win_slot_d = 4'(s);
            end
        end
        req_d = rank(win_lvl_d) > rank(cur_d);
        vec_d = slot_vector(win_slot_d);
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cur_q <= LVL_RESET;
        end else begin
            cur_q <= cur_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            req_q <= 1'b0;
            vec_q <= VEC_RESET;
            win_lvl_q <= LVL_RESET;
            win_slot_q <= 4'h0;
        end else begin
            req_q <= req_d;
            vec_q <= vec_d;
            win_lvl_q <= win_lvl_d;
            win_slot_q <= win_slot_d;
        end
    end

    // snapshot of the sources behind the accepted slot
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            flags_q <= FLAGS_RESET;
        end else if (accept) begin
            flags_q <= src_req & SLOT_MASK[win_slot_q];
        end
    end

    // release of the stopped state: ext 0/1 only when level-detected
    always_comb begin
        wake_d = 1'b0;
        if (src_req[SRC_EXT0] && ext_level_detect_i[0]) begin
            wake_d = 1'b1;
        end
        if (src_req[SRC_EXT1] && ext_level_detect_i[1]) begin
            wake_d = 1'b1;
        end
        // these sources release it in either detection mode
        if (src_req[SRC_EXT2] || src_req[SRC_EXT4] || src_req[SRC_EXT5]
                || src_req[SRC_PORT0]) begin
            wake_d = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            wake_q <= 1'b0;
        end else begin
            wake_q <= wake_d;
        end
    end

    assign irq_req_o = req_q;
    assign vector_o = vec_q;
    assign source_flag_list_o = flags_q;
    assign service_level_o = cur_q;
    assign wake_o = wake_q;

endmodule // vectored_irq_ctrl

// ### test/irq_ctrl_asserts.sv
module irq_ctrl_asserts
    import irq_ctrl_pkg::*;
(
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic ext_request_0_i,
    input wire logic [NUM_EXT_TOP-1:0] ext_level_detect_i,
    input wire logic irq_ack_i,
    input wire logic irq_return_i,
    input wire logic irq_req_o,
    input wire logic [VEC_W-1:0] vector_o,
    input wire logic [NUM_SRC-1:0] source_flag_list_o,
    input wire lvl_t service_level_o,
    input wire logic wake_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    // rank of a gray level code
    function automatic int rk(logic [1:0] l);
        return l == 2'h2 ? 3 : l == 2'h3 ? 2 : int'(l);
    endfunction
    wire logic acc = irq_req_o && irq_ack_i;
    property p_vec; irq_req_o |-> vector_o[2:0] == 3'h3 && vector_o <= 17'h0004B; endproperty
    a_vec: assert property (p_vec) else $error("bad vector");
    property p_nest; acc |=> rk(service_level_o) > rk($past(service_level_o)); endproperty
    a_nest: assert property (p_nest) else $error("level not raised");
    property p_flags;
        acc |=> source_flag_list_o != 24'h0
            && (source_flag_list_o & ~SLOT_MASK[$past(vector_o) >> 3]) == 24'h0;
    endproperty
    a_flags: assert property (p_flags) else $error("bad flag list");
    property p_top; acc ##1 service_level_o == LVL_TOP |-> $past(vector_o) <= 17'h0000B; endproperty
    a_top: assert property (p_top) else $error("top level on shared slot");
    property p_ret;
        irq_return_i && !acc && service_level_o != LVL_NONE
            |=> rk(service_level_o) < rk($past(service_level_o));
    endproperty
    a_ret: assert property (p_ret) else $error("level not restored");
    property p_wake; ext_request_0_i && ext_level_detect_i[0] |=> wake_o; endproperty
    a_wake: assert property (p_wake) else $error("no wake");
    property p_ceil; service_level_o == LVL_TOP |-> !irq_req_o; endproperty
    a_ceil: assert property (p_ceil) else $error("offer above top");
    property p_hold; !acc |=> $stable(source_flag_list_o); endproperty
    a_hold: assert property (p_hold) else $error("flag list moved");
    c_acc: cover property (acc);
    c_nest: cover property (acc && service_level_o != LVL_NONE);
    c_ret: cover property (irq_return_i && service_level_o != LVL_NONE);
endmodule // irq_ctrl_asserts
bind vectored_irq_ctrl irq_ctrl_asserts chk (.*);

// ### test/core_model.sv
module core_model (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic go_i,
    input wire logic [1:0] delay_i,
    input wire logic req_i,
    output logic ack_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] wait_q;
    // one-cycle accept pulse after delay_i + 1 cycles of a standing offer
    always_ff @(posedge clk_i) begin
        if (srst_i || !go_i || !req_i || ack_o) begin
            wait_q <= 2'h0;
            ack_o <= 1'b0;
        end else begin
            ack_o <= wait_q == delay_i;
            wait_q <= wait_q + 2'h1;
        end
    end
endmodule // core_model

// ### test/tb_multilevel_vectored_interrupt_ctrl.sv
module tb_multilevel_vectored_interrupt_ctrl import irq_ctrl_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0, srst_i = 1, ret = 0, go = 0, ack, req, wake;
    logic [1:0] dly = 0, top = 0, ldet = 0;
    logic [23:0] s = 0, flags;
    logic [9:0] en = 0, hi = 0;
    logic [VEC_W-1:0] vec;
    lvl_t lvl;
    int seed = 92, mismatches = 0, tests_run = 0, t = 0;
    always #2 clk_i = ~clk_i;
    vectored_irq_ctrl uut (.clk_i(clk_i), .srst_i(srst_i), .ext_request_0_i(s[0]),
        .ext_request_1_i(s[1]), .ext_request_2_i(s[2]), .timer0_low_event_i(s[3]),
        .ext_request_4_i(s[4]), .ir_receiver_event_i(s[5]), .ext_request_3_i(s[6]),
        .ext_request_5_i(s[7]), .base_timer_event_a_i(s[8]), .base_timer_event_b_i(s[9]),
        .timer0_high_event_i(s[10]), .timer1_low_event_i(s[11]), .timer1_high_event_i(s[12]),
        .sync_serial_0_i(s[13]), .uart_receive_i(s[14]), .async_sync_serial_1_i(s[15]),
        .uart_transmit_i(s[16]), .converter_done_i(s[17]), .eight_bit_timer_c_i(s[18]),
        .eight_bit_timer_d_i(s[19]), .port0_event_i(s[20]), .eight_bit_timer_a_i(s[21]),
        .eight_bit_timer_b_i(s[22]), .twelve_bit_modulators_i(s[23]), .slot_enable_i(en),
        .slot_high_i(hi), .ext_top_i(top), .ext_level_detect_i(ldet), .irq_ack_i(ack),
        .irq_return_i(ret), .irq_req_o(req), .vector_o(vec), .source_flag_list_o(flags),
        .service_level_o(lvl), .wake_o(wake));
    core_model partner (.clk_i(clk_i), .srst_i(srst_i), .go_i(go), .delay_i(dly),
        .req_i(req), .ack_o(ack));
    function automatic int lv(int k);
        return (k < 2 && top[k]) ? 3 : hi[k] ? 2 : 1;
    endfunction
    function automatic logic [23:0] code(int r);
        return r == 3 ? 24'h2 : r == 2 ? 24'h3 : 24'(r);
    endfunction
    function automatic int pick(int cur);
        int b = -1;
        for (int k = 0; k < NUM_SLOT; k++) begin
            if (en[k] && |(s & SLOT_MASK[k]) && lv(k) > cur && (b < 0 || lv(k) > lv(b))) b = k;
        end
        return b;
    endfunction
    task automatic cmp(input logic [23:0] g, e);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    // let the core accept the standing offer, then wait one edge for the answer
    task automatic grab();
        @(posedge clk_i);
        go <= 1;
        for (int n = 0; n < 20 && !ack; n++) @(posedge clk_i);
        go <= 0;
        @(posedge clk_i);
        #1;
    endtask
    task automatic trial(input logic [23:0] src, input logic [9:0] e, h, input logic [1:0] tp, ld);
        int b, cur, d;
        int st[4];
        @(posedge clk_i);
        s <= src; en <= e; hi <= h; top <= tp; ldet <= ld; dly <= 2'($random(seed));
        repeat (3) @(posedge clk_i);
        #1;
        cmp(24'(wake), 24'(src[0] & ld[0] | src[1] & ld[1] | src[2] | src[4] | src[7] | src[20]));
        cur = 0;
        d = 0;
        for (b = pick(0); b >= 0; b = pick(cur)) begin
            cmp(24'(req), 24'h1);
            cmp(24'(vec), 24'(VEC_BASE + VEC_STEP * b));
            grab();
            st[d] = cur;
            d++;
            cur = lv(b);
            cmp(24'(lvl), code(cur));
            cmp(flags, src & SLOT_MASK[b]);
        end
        cmp(24'(req), 24'h0);
        while (d > 0) begin
            @(posedge clk_i);
            ret <= 1;
            @(posedge clk_i);
            ret <= 0;
            #1;
            d--;
            cur = st[d];
            cmp(24'(lvl), code(cur));
        end
        @(posedge clk_i);
        s <= 0;
        t++;
        $display("test %0d done", t);
    endtask
    // low, high and top requests arrive one by one and nest; handlers clear in the same cycle as the return
    task automatic nest();
        logic [23:0] bit_of [3];
        int b;
        int cur;
        int st [3];
        bit_of = '{24'h000008, 24'h100000, 24'h000001};
        cur = 0;
        @(posedge clk_i);
        en <= 10'h3FF;
        hi <= 10'h200;
        top <= 2'h1;
        ldet <= 2'h0;
        dly <= 2'($random(seed));
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_i);
            s <= s | bit_of[i];
            repeat (2) @(posedge clk_i);
            #1;
            b = pick(cur);
            cmp(24'(req), 24'h1);
            cmp(24'(vec), 24'(VEC_BASE + VEC_STEP * b));
            grab();
            st[i] = cur;
            cur = lv(b);
            cmp(24'(lvl), code(cur));
            cmp(flags, bit_of[i]);
        end
        for (int i = 2; i >= 0; i--) begin
            @(posedge clk_i);
            s <= s & ~bit_of[i];
            ret <= 1;
            @(posedge clk_i);
            ret <= 0;
            #1;
            cmp(24'(lvl), code(st[i]));
            cmp(24'(req), 24'h0);
        end
        t++;
        $display("test %0d done", t);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        srst_i <= 0;
        for (int k = 0; k < NUM_SRC; k++) trial(24'h1 << k, 10'h3FF, 10'h0, 2'h0, 2'h3);
        trial(24'hFFFFFF, 10'h3FF, 10'h0, 2'h0, 2'h0);
        trial(24'hFFFFFF, 10'h3FF, 10'h200, 2'h2, 2'h0);
        trial(24'hFFFFFF, 10'h3FF, 10'h3FE, 2'h1, 2'h0);
        nest();
        repeat (60) trial(24'($random(seed) & $random(seed)), 10'($random(seed)),
            10'($random(seed)), 2'($random(seed)), 2'($random(seed)));
        end_sim();
    end
    initial begin
        #200000;
        mismatches++;
        end_sim();
    end
endmodule // tb_multilevel_vectored_interrupt_ctrl
